// ===== logic/bbx_pkg.sv
// shared types, constants and helpers for the branch and bit operation executor
package bbx_pkg;

  // ==========================================================
  // operation codes delivered by the decoder
  typedef enum logic [4:0]
  {
    OP_RELATIVE_CALL,
    OP_INDIRECT_CALL,
    OP_DIRECT_CALL,
    OP_COMPARE_SKIP_EQUAL,
    OP_COMPARE,
    OP_COMPARE_CARRY,
    OP_COMPARE_IMM,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_ON_FLAG_SET,
    OP_BRANCH_ON_FLAG_CLEAR,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_LOGICAL_SHIFT_LEFT,
    OP_LOGICAL_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_TFLAG_STORE_BIT,
    OP_TFLAG_LOAD_BIT,
    OP_STATUS_BIT_SET,
    OP_STATUS_BIT_CLEAR
  } bbx_op_t;

  // ==========================================================
  // flag positions inside cpu_flag_register
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ==========================================================
  // reset values and cycle counts
  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [2:0]  CYC_SINGLE      = 3'h1;
  localparam logic [2:0]  CYC_REL_CALL    = 3'h3;
  localparam logic [2:0]  CYC_IND_CALL    = 3'h3;
  localparam logic [2:0]  CYC_DIR_CALL    = 3'h4;
  localparam logic [2:0]  CYC_BRANCH_TAKEN = 3'h2;
  localparam logic [2:0]  CYC_IO_BIT      = 3'h2;
  localparam logic [15:0] WORDS_ONE       = 16'h0001;
  localparam logic [15:0] WORDS_TWO       = 16'h0002;

  // ==========================================================
  // request from the decoder and side effects toward the core
  typedef struct packed
  {
    bbx_op_t     op;
    logic [7:0]  rd_val;
    logic [7:0]  rr_val;
    logic [7:0]  imm;
    logic [7:0]  io_val;
    logic [2:0]  bit_sel;
    logic [2:0]  flag_sel;
    logic [11:0] offset;
    logic [15:0] target;
    logic [15:0] z_ptr;
    logic        next_two_word;
  } bbx_req_t;

  typedef struct packed
  {
    logic        reg_we;
    logic [7:0]  reg_data;
    logic        io_we;
    logic [7:0]  io_data;
    logic        push_we;
    logic [15:0] push_addr;
  } bbx_res_t;

  // ==========================================================
  // pick one bit out of a byte
  function automatic logic bit_of(input logic [7:0] v, input logic [2:0] idx);
    bit_of = v[idx];
  endfunction

endpackage

// ===== logic/bbx_cond.sv
// branch and skip condition evaluation
`timescale 1ns/1ps
module bbx_cond
(
  // decoded operation
  input  wire bbx_pkg::bbx_op_t op_i,
  input  wire logic [7:0]       flags_i,
  input  wire logic [7:0]       rd_val_i,
  input  wire logic [7:0]       rr_val_i,
  input  wire logic [7:0]       io_val_i,
  input  wire logic [2:0]       bit_sel_i,
  input  wire logic [2:0]       flag_sel_i,
  // result
  output logic                  taken_o
);

  // ==========================================================
  // operand bits
  wire reg_bit    = bbx_pkg::bit_of(rr_val_i, bit_sel_i);
  wire io_bit     = bbx_pkg::bit_of(io_val_i, bit_sel_i);
  wire flag_bit   = bbx_pkg::bit_of(flags_i, flag_sel_i);
  wire signed_lt  = flags_i[bbx_pkg::FLAG_N] ^ flags_i[bbx_pkg::FLAG_V];
  wire equal      = (rd_val_i == rr_val_i);

  // ==========================================================
  // condition select
  always_comb
  begin
    case (op_i)
      bbx_pkg::OP_COMPARE_SKIP_EQUAL:   taken_o = equal;
      bbx_pkg::OP_SKIP_REG_BIT_CLEAR:   taken_o = ~reg_bit;
      bbx_pkg::OP_SKIP_REG_BIT_SET:     taken_o = reg_bit;
      bbx_pkg::OP_SKIP_IO_BIT_CLEAR:    taken_o = ~io_bit;
      bbx_pkg::OP_SKIP_IO_BIT_SET:      taken_o = io_bit;
      // any flag, so carry, half-carry and interrupt aliases land here
      bbx_pkg::OP_BRANCH_ON_FLAG_SET:   taken_o = flag_bit;
      bbx_pkg::OP_BRANCH_ON_FLAG_CLEAR: taken_o = ~flag_bit;
      bbx_pkg::OP_BRANCH_SIGNED_GE:     taken_o = ~signed_lt;
      bbx_pkg::OP_BRANCH_SIGNED_LT:     taken_o = signed_lt;
      default:                          taken_o = 1'b0;
    endcase
  end

endmodule

// ===== logic/bbx_shift_cmp.sv
// compare and shift arithmetic with flag generation
`timescale 1ns/1ps
module bbx_shift_cmp
(
  // operands
  input  wire bbx_pkg::bbx_op_t op_i,
  input  wire logic [7:0]       a_i,
  input  wire logic [7:0]       b_i,
  input  wire logic [7:0]       flags_i,
  // results
  output logic [7:0]            res_o,
  output logic [7:0]            flags_o
);

  // ==========================================================
  // subtraction for the compare group
  wire       cin   = (op_i == bbx_pkg::OP_COMPARE_CARRY) & flags_i[bbx_pkg::FLAG_C];
  wire [8:0] diff  = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
  wire [4:0] hdiff = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin};
  wire       ovf   = (a_i[7] & ~b_i[7] & ~diff[7]) | (~a_i[7] & b_i[7] & diff[7]);
  wire       zero  = (diff[7:0] == 8'h00);

  // ==========================================================
  // shifter and flag merge
  always_comb
  begin
    logic sh_c;
    sh_c    = 1'b0;
    res_o   = a_i;
    flags_o = flags_i;
    case (op_i)
      bbx_pkg::OP_COMPARE,
      bbx_pkg::OP_COMPARE_CARRY,
      bbx_pkg::OP_COMPARE_IMM:
      begin
        // difference goes out on res_o; the executor keeps only the flags
        res_o                   = diff[7:0];
        flags_o[bbx_pkg::FLAG_C] = diff[8];
        flags_o[bbx_pkg::FLAG_H] = hdiff[4];
        flags_o[bbx_pkg::FLAG_V] = ovf;
        flags_o[bbx_pkg::FLAG_N] = diff[7];
        // with carry the zero flag can only stay or fall
        flags_o[bbx_pkg::FLAG_Z] = (op_i == bbx_pkg::OP_COMPARE_CARRY) ?
                                   (zero & flags_i[bbx_pkg::FLAG_Z]) : zero;
      end
      bbx_pkg::OP_LOGICAL_SHIFT_LEFT:
      begin
        res_o = {a_i[6:0], 1'b0};
        sh_c  = a_i[7];
      end
      bbx_pkg::OP_ROTATE_LEFT_CARRY:
      begin
        res_o = {a_i[6:0], flags_i[bbx_pkg::FLAG_C]};
        sh_c  = a_i[7];
      end
      bbx_pkg::OP_LOGICAL_SHIFT_RIGHT:
      begin
        res_o = {1'b0, a_i[7:1]};
        sh_c  = a_i[0];
      end
      bbx_pkg::OP_ROTATE_RIGHT_CARRY:
      begin
        res_o = {flags_i[bbx_pkg::FLAG_C], a_i[7:1]};
        sh_c  = a_i[0];
      end
      bbx_pkg::OP_ARITH_SHIFT_RIGHT:
      begin
        res_o = {a_i[7], a_i[7:1]};
        sh_c  = a_i[0];
      end
      default:
      begin
        res_o = a_i;
      end
    endcase
    // shared flag update for all shifts and rotates
    case (op_i)
      bbx_pkg::OP_LOGICAL_SHIFT_LEFT,
      bbx_pkg::OP_ROTATE_LEFT_CARRY,
      bbx_pkg::OP_LOGICAL_SHIFT_RIGHT,
      bbx_pkg::OP_ROTATE_RIGHT_CARRY,
      bbx_pkg::OP_ARITH_SHIFT_RIGHT:
      begin
        flags_o[bbx_pkg::FLAG_C] = sh_c;
        flags_o[bbx_pkg::FLAG_Z] = (res_o == 8'h00);
        flags_o[bbx_pkg::FLAG_N] = res_o[7];
        flags_o[bbx_pkg::FLAG_V] = res_o[7] ^ sh_c;
      end
      default:
      begin
        flags_o[bbx_pkg::FLAG_T] = flags_o[bbx_pkg::FLAG_T];
      end
    endcase
  end

endmodule

// ===== logic/bbx_exec.sv
// execution unit for control-flow and bit-manipulation operations
// operands are sampled only at the accept edge, so req_i may move afterwards
// io bit ops return the whole byte; read-modify-write order is the caller's
// the s flag is left alone by compares and shifts
// a request is refused only by req_ready_o low; nothing signals an error
`timescale 1ns/1ps
module bbx_exec
(
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  // request from the decoder
  input  wire logic             req_valid_i,
  input  wire bbx_pkg::bbx_req_t req_i,
  output logic                  req_ready_o,
  // completion and architectural state
  output logic                  done_o,
  output logic [15:0]           pc_o,
  output logic [7:0]            flags_o,
  // register, io and stack side effects
  output bbx_pkg::bbx_res_t     res_o
);

  // ==========================================================
  // state and storage
  typedef enum logic {ST_IDLE, ST_WAIT} bbx_state_t;

  bbx_state_t        state_r;
  logic [2:0]        cnt_r;
  logic [15:0]       pc_r;
  logic [7:0]        flags_r;
  bbx_pkg::bbx_res_t res_r;
  logic              done_r;
  logic [15:0]       pend_pc_r;
  logic [7:0]        pend_flags_r;
  bbx_pkg::bbx_res_t pend_res_r;

  // ==========================================================
  // helper units
  logic       taken_w;
  logic [7:0] alu_res_w;
  logic [7:0] alu_flags_w;

  // compare-immediate takes its subtrahend from imm
  wire [7:0] alu_b_w = (req_i.op == bbx_pkg::OP_COMPARE_IMM) ? req_i.imm : req_i.rr_val;

  bbx_cond u_cond
  (
    .op_i       (req_i.op),
    .flags_i    (flags_r),
    .rd_val_i   (req_i.rd_val),
    .rr_val_i   (req_i.rr_val),
    .io_val_i   (req_i.io_val),
    .bit_sel_i  (req_i.bit_sel),
    .flag_sel_i (req_i.flag_sel),
    .taken_o    (taken_w)
  );

  bbx_shift_cmp u_shift_cmp
  (
    .op_i    (req_i.op),
    .a_i     (req_i.rd_val),
    .b_i     (alu_b_w),
    .flags_i (flags_r),
    .res_o   (alu_res_w),
    .flags_o (alu_flags_w)
  );

  // ==========================================================
  // address arithmetic
  wire [15:0] off_ext_w  = {{4{req_i.offset[11]}}, req_i.offset};
  wire [15:0] pc_inc_w   = pc_r + bbx_pkg::WORDS_ONE;
  wire [15:0] pc_rel_w   = pc_r + off_ext_w + bbx_pkg::WORDS_ONE;

  // skip distance and its cycle cost follow the skipped word count
  wire [15:0] skip_len_w = req_i.next_two_word ? bbx_pkg::WORDS_TWO : bbx_pkg::WORDS_ONE;
  wire [15:0] skip_pc_w  = taken_w ? (pc_inc_w + skip_len_w) : pc_inc_w;
  wire [2:0]  skip_cyc_w = taken_w ? (bbx_pkg::CYC_SINGLE + skip_len_w[2:0])
                                   : bbx_pkg::CYC_SINGLE;

  // one-hot masks for single-bit io and flag writes
  wire [7:0]  bit_mask_w = 8'h01 << req_i.bit_sel;
  wire [7:0]  flag_mask_w = 8'h01 << req_i.flag_sel;

  // ==========================================================
  // per-operation outcome
  logic [15:0]       nx_pc;
  logic [7:0]        nx_flags;
  bbx_pkg::bbx_res_t nx_res;
  logic [2:0]        nx_cycles;

  always_comb
  begin
    nx_pc     = pc_inc_w;
    nx_flags  = flags_r;
    nx_res    = '0;
    nx_cycles = bbx_pkg::CYC_SINGLE;
    case (req_i.op)
      bbx_pkg::OP_RELATIVE_CALL:
      begin
        nx_pc            = pc_rel_w;
        nx_res.push_we   = 1'b1;
        nx_res.push_addr = pc_inc_w;
        nx_cycles        = bbx_pkg::CYC_REL_CALL;
      end
      bbx_pkg::OP_INDIRECT_CALL:
      begin
        nx_pc            = req_i.z_ptr;
        nx_res.push_we   = 1'b1;
        nx_res.push_addr = pc_inc_w;
        nx_cycles        = bbx_pkg::CYC_IND_CALL;
      end
      bbx_pkg::OP_DIRECT_CALL:
      begin
        // two-word instruction, so return lands after the target word
        nx_pc            = req_i.target;
        nx_res.push_we   = 1'b1;
        nx_res.push_addr = pc_r + bbx_pkg::WORDS_TWO;
        nx_cycles        = bbx_pkg::CYC_DIR_CALL;
      end
      bbx_pkg::OP_COMPARE_SKIP_EQUAL,
      bbx_pkg::OP_SKIP_REG_BIT_CLEAR,
      bbx_pkg::OP_SKIP_REG_BIT_SET,
      bbx_pkg::OP_SKIP_IO_BIT_CLEAR,
      bbx_pkg::OP_SKIP_IO_BIT_SET:
      begin
        // skipping costs one or two extra cycles
        nx_pc     = skip_pc_w;
        nx_cycles = skip_cyc_w;
      end
      bbx_pkg::OP_COMPARE,
      bbx_pkg::OP_COMPARE_CARRY,
      bbx_pkg::OP_COMPARE_IMM:
      begin
        // difference is dropped, only flags land
        nx_flags = alu_flags_w;
      end
      bbx_pkg::OP_BRANCH_ON_FLAG_SET,
      bbx_pkg::OP_BRANCH_ON_FLAG_CLEAR,
      bbx_pkg::OP_BRANCH_SIGNED_GE,
      bbx_pkg::OP_BRANCH_SIGNED_LT:
      begin
        // a taken branch costs one extra cycle
        nx_pc     = taken_w ? pc_rel_w : pc_inc_w;
        nx_cycles = taken_w ? bbx_pkg::CYC_BRANCH_TAKEN
                            : bbx_pkg::CYC_SINGLE;
      end
      bbx_pkg::OP_IO_BIT_SET:
      begin
        nx_res.io_we   = 1'b1;
        nx_res.io_data = req_i.io_val | bit_mask_w;
        nx_cycles      = bbx_pkg::CYC_IO_BIT;
      end
      bbx_pkg::OP_IO_BIT_CLEAR:
      begin
        nx_res.io_we   = 1'b1;
        nx_res.io_data = req_i.io_val & ~bit_mask_w;
        nx_cycles      = bbx_pkg::CYC_IO_BIT;
      end
      bbx_pkg::OP_LOGICAL_SHIFT_LEFT,
      bbx_pkg::OP_ROTATE_LEFT_CARRY,
      bbx_pkg::OP_LOGICAL_SHIFT_RIGHT,
      bbx_pkg::OP_ROTATE_RIGHT_CARRY,
      bbx_pkg::OP_ARITH_SHIFT_RIGHT:
      begin
        // result and new flags both come from the shifter
        nx_res.reg_we   = 1'b1;
        nx_res.reg_data = alu_res_w;
        nx_flags        = alu_flags_w;
      end
      bbx_pkg::OP_TFLAG_STORE_BIT:
      begin
        nx_flags[bbx_pkg::FLAG_T] = bbx_pkg::bit_of(req_i.rr_val, req_i.bit_sel);
      end
      bbx_pkg::OP_TFLAG_LOAD_BIT:
      begin
        nx_res.reg_we   = 1'b1;
        nx_res.reg_data = flags_r[bbx_pkg::FLAG_T] ? (req_i.rd_val | bit_mask_w)
                                                   : (req_i.rd_val & ~bit_mask_w);
      end
      bbx_pkg::OP_STATUS_BIT_SET:
      begin
        nx_flags = flags_r | flag_mask_w;
      end
      bbx_pkg::OP_STATUS_BIT_CLEAR:
      begin
        nx_flags = flags_r & ~flag_mask_w;
      end
      default:
      begin
        nx_cycles = bbx_pkg::CYC_SINGLE;
      end
    endcase
  end

  // ==========================================================
  // sequencing: accept, hold for the cycle count, then commit
  wire accept_w   = req_valid_i & (state_r == ST_IDLE);
  wire commit_now = accept_w & (nx_cycles == bbx_pkg::CYC_SINGLE);
  wire commit_pend = (state_r == ST_WAIT) & (cnt_r == 3'h1);
  wire commit_w   = commit_now | commit_pend;

  // commit source: fresh outcome or the one held while waiting
  wire [15:0]        cm_pc    = commit_pend ? pend_pc_r    : nx_pc;
  wire [7:0]         cm_flags = commit_pend ? pend_flags_r : nx_flags;
  bbx_pkg::bbx_res_t cm_res;
  assign cm_res = commit_pend ? pend_res_r : nx_res;

  // handshake
  assign req_ready_o = (state_r == ST_IDLE);

  // multi-cycle hold state
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state_r      <= ST_IDLE;
      cnt_r        <= 3'h0;
      pend_pc_r    <= bbx_pkg::PC_RESET;
      pend_flags_r <= bbx_pkg::FLAGS_RESET;
      pend_res_r   <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (accept_w && !commit_now)
          begin
            state_r      <= ST_WAIT;
            cnt_r        <= nx_cycles - 3'h1;
            pend_pc_r    <= nx_pc;
            pend_flags_r <= nx_flags;
            pend_res_r   <= nx_res;
          end
        end
        ST_WAIT:
        begin
          cnt_r <= cnt_r - 3'h1;
          if (commit_pend)
          begin
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // architectural commit; push and pc change land together
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      pc_r    <= bbx_pkg::PC_RESET;
      flags_r <= bbx_pkg::FLAGS_RESET;
      res_r   <= '0;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= commit_w;
      res_r  <= commit_w ? cm_res : '0;
      if (commit_w)
      begin
        pc_r    <= cm_pc;
        flags_r <= cm_flags;
      end
    end
  end

  // ==========================================================
  // outputs
  assign done_o  = done_r;
  assign pc_o    = pc_r;
  assign flags_o = flags_r;
  assign res_o   = res_r;

endmodule

// ===== dv/bbx_exec_asserts.sv
// port-level checks for the branch and bit operation executor
`timescale 1ns/1ps
module bbx_exec_asserts
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  // request side
  input  wire logic              req_valid_i,
  input  wire bbx_pkg::bbx_req_t req_i,
  input  wire logic              req_ready_o,
  // results
  input  wire logic              done_o,
  input  wire logic [15:0]       pc_o,
  input  wire logic [7:0]        flags_o,
  input  wire bbx_pkg::bbx_res_t res_o
);
  // ==========================================================
  // accept strobe and decoded helpers
  wire acc = req_valid_i && req_ready_o;
  wire bbx_pkg::bbx_op_t op = req_i.op;
  wire nxv = flags_o[2] ^ flags_o[3];
  wire sbit = flags_o[req_i.flag_sel];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // ==========================================================
  // properties
  property p_res_idle;
    !done_o |-> res_o == '0;
  endproperty
  a_res_idle: assert property (p_res_idle) else $error("side effect outside done");
  property p_done_ready;
    done_o |-> req_ready_o;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("busy at commit");
  property p_dir_call;
    acc && op == bbx_pkg::OP_DIRECT_CALL |=> (!req_ready_o)[*3] ##1 (done_o && res_o.push_we
      && pc_o == $past(req_i.target, 4) && res_o.push_addr == $past(pc_o, 4) + 16'h0002
      && flags_o == $past(flags_o, 4));
  endproperty
  a_dir_call: assert property (p_dir_call) else $error("direct call wrong");
  property p_ind_call;
    acc && op == bbx_pkg::OP_INDIRECT_CALL |-> ##3 (done_o && pc_o == $past(req_i.z_ptr, 3)
      && res_o.push_addr == $past(pc_o, 3) + 16'h0001);
  endproperty
  a_ind_call: assert property (p_ind_call) else $error("indirect call wrong");
  property p_ge;
    acc && op == bbx_pkg::OP_BRANCH_SIGNED_GE |=> done_o == $past(nxv);
  endproperty
  a_ge: assert property (p_ge) else $error("signed ge timing wrong");
  property p_lt;
    acc && op == bbx_pkg::OP_BRANCH_SIGNED_LT |=> done_o != $past(nxv);
  endproperty
  a_lt: assert property (p_lt) else $error("signed lt timing wrong");
  property p_brs;
    acc && op == bbx_pkg::OP_BRANCH_ON_FLAG_SET |=> done_o == !$past(sbit);
  endproperty
  a_brs: assert property (p_brs) else $error("flag branch timing wrong");
  property p_io_set;
    acc && op == bbx_pkg::OP_IO_BIT_SET |-> ##2 (done_o && res_o.io_we
      && res_o.io_data == ($past(req_i.io_val, 2) | (8'h01 << $past(req_i.bit_sel, 2))));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");
  property p_flag_set;
    acc && op == bbx_pkg::OP_STATUS_BIT_SET
      |=> done_o && flags_o == ($past(flags_o) | (8'h01 << $past(req_i.flag_sel)));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
  property p_lsl;
    acc && op == bbx_pkg::OP_LOGICAL_SHIFT_LEFT |=> done_o && res_o.reg_we
      && res_o.reg_data == {$past(req_i.rd_val[6:0]), 1'b0} && flags_o[0] == $past(req_i.rd_val[7]);
  endproperty
  a_lsl: assert property (p_lsl) else $error("shift left wrong");

  // ==========================================================
  // main scenarios reached
  c_dir: cover property (acc && op == bbx_pkg::OP_DIRECT_CALL);
  c_skip2: cover property (acc && op == bbx_pkg::OP_SKIP_IO_BIT_SET && req_i.next_two_word);
  c_taken: cover property (acc && op == bbx_pkg::OP_BRANCH_SIGNED_GE && !nxv);
endmodule

// ===== dv/tb.sv
// self-checking bench for the branch and bit operation executor
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // design signals and bench state
  logic              clock_i;
  logic              resetn_i;
  logic              req_valid_i;
  bbx_pkg::bbx_req_t rq;
  logic              req_ready_o;
  logic              done_o;
  logic [15:0]       pc_o;
  logic [7:0]        flags_o;
  bbx_pkg::bbx_res_t res_o;
  logic [15:0]       p0;
  logic [7:0]        f0;
  logic [15:0]       cyc;
  int                failures;
  int                tests_run;
  localparam bbx_pkg::bbx_op_t SKIPS[5] = '{bbx_pkg::OP_COMPARE_SKIP_EQUAL,
    bbx_pkg::OP_SKIP_REG_BIT_CLEAR, bbx_pkg::OP_SKIP_REG_BIT_SET,
    bbx_pkg::OP_SKIP_IO_BIT_CLEAR, bbx_pkg::OP_SKIP_IO_BIT_SET};
  localparam bbx_pkg::bbx_op_t SHIFTS[5] = '{bbx_pkg::OP_LOGICAL_SHIFT_LEFT,
    bbx_pkg::OP_LOGICAL_SHIFT_RIGHT, bbx_pkg::OP_ROTATE_LEFT_CARRY,
    bbx_pkg::OP_ROTATE_RIGHT_CARRY, bbx_pkg::OP_ARITH_SHIFT_RIGHT};
  localparam logic [7:0] SH_RES[5] = '{8'h02, 8'h40, 8'h03, 8'hc0, 8'hc0};

  bbx_exec bbx_exec_i (.clock_i(clock_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_i(rq), .req_ready_o(req_ready_o), .done_o(done_o), .pc_o(pc_o),
    .flags_o(flags_o), .res_o(res_o));

  // ==========================================================
  // shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // drive one request at a falling edge, return in the done cycle
  task automatic issue(input bbx_pkg::bbx_op_t op);
    // one idle edge between requests, so valid never toggles in one step
    @(negedge clock_i);
    rq.op = op;
    p0 = pc_o;
    f0 = flags_o;
    req_valid_i = 1'b1;
    @(posedge clock_i);
    cyc = 16'h0001;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && cyc < 16'h0008)
    begin
      @(negedge clock_i);
      cyc++;
    end
  endtask
  task automatic set_flags(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      rq.flag_sel = i[2:0];
      issue(v[i] ? bbx_pkg::OP_STATUS_BIT_SET : bbx_pkg::OP_STATUS_BIT_CLEAR);
      f0[i] = v[i];
      check("flag_op", flags_o, f0);
      check("flag_cyc", cyc, 16'h0001);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_branch();
    logic tk;
    for (int i = 0; i < 32; i++)
    begin
      if (i % 16 == 0)
        set_flags(i < 16 ? 8'ha5 : 8'h5a);
      rq.flag_sel = i[2:0];
      rq.offset = i[3] ? 12'hffd : 12'h012;
      tk = flags_o[i[2:0]] ^ i[3];
      issue(i[3] ? bbx_pkg::OP_BRANCH_ON_FLAG_CLEAR : bbx_pkg::OP_BRANCH_ON_FLAG_SET);
      check("br_pc", pc_o, p0 + (tk ? {{4{rq.offset[11]}}, rq.offset} + 16'h1 : 16'h1));
      check("br_cyc", cyc, tk ? 16'h0002 : 16'h0001);
      check("br_flags", flags_o, f0);
    end
  endtask
  task automatic t_signed();
    for (int i = 0; i < 4; i++)
    begin
      set_flags({4'h0, i[1], i[0], 2'b00});
      rq.offset = 12'h020;
      issue(bbx_pkg::OP_BRANCH_SIGNED_GE);
      check("ge_pc", pc_o, p0 + ((i[1] ^ i[0]) ? 16'h0001 : 16'h0021));
      issue(bbx_pkg::OP_BRANCH_SIGNED_LT);
      check("lt_cyc", cyc, (i[1] ^ i[0]) ? 16'h0002 : 16'h0001);
      check("lt_flags", flags_o, f0);
    end
  endtask
  task automatic t_calls();
    rq.offset = 12'h100;
    issue(bbx_pkg::OP_RELATIVE_CALL);
    check("rel_call_pc", pc_o, p0 + 16'h0101);
    check("rel_call_push", res_o.push_addr, p0 + 16'h0001);
    check("rel_call_cyc", cyc, 16'h0003);
    rq.z_ptr = 16'h1234;
    issue(bbx_pkg::OP_INDIRECT_CALL);
    check("ind_call_pc", pc_o, 16'h1234);
    check("ind_call_push", {res_o.push_we, res_o.push_addr[14:0]}, p0 + 16'h8001);
    check("ind_call_cyc", cyc, 16'h0003);
    rq.target = 16'h0bee;
    issue(bbx_pkg::OP_DIRECT_CALL);
    check("call_pc", pc_o, 16'h0bee);
    check("call_push", {res_o.push_we, res_o.push_addr[14:0]}, p0 + 16'h8002);
    check("call_cyc", cyc, 16'h0004);
    check("call_flags", flags_o, f0);
  endtask
  task automatic t_skip();
    logic sk;
    for (int i = 0; i < 20; i++)
    begin
      rq.bit_sel = 3'h4;
      rq.rd_val = i[1] ? 8'h10 : 8'h00;
      // equality compares against 0x10; register-bit skips test rr itself
      rq.rr_val = (i < 4) ? 8'h10 : rq.rd_val;
      rq.io_val = rq.rd_val;
      rq.next_two_word = i[0];
      sk = (i / 4 == 0) ? i[1] : ((i / 4) % 2 == 1) ? !i[1] : i[1];
      issue(SKIPS[i / 4]);
      check("skip_pc", pc_o, p0 + (sk ? (i[0] ? 16'h3 : 16'h2) : 16'h1));
      check("skip_cyc", cyc, sk ? (i[0] ? 16'h3 : 16'h2) : 16'h1);
      check("skip_flags", flags_o, f0);
    end
  endtask
  task automatic t_bits();
    rq.io_val = 8'h5a;
    rq.bit_sel = 3'h0;
    issue(bbx_pkg::OP_IO_BIT_SET);
    check("sbit", {res_o.io_we, res_o.io_data, cyc[6:0]}, 16'had82);
    rq.bit_sel = 3'h6;
    issue(bbx_pkg::OP_IO_BIT_CLEAR);
    check("cbit", {res_o.io_we, res_o.io_data, cyc[6:0]}, 16'h8d02);
    check("cbit_flags", flags_o, f0);
    rq.rd_val = 8'h20;
    rq.rr_val = 8'h20;
    rq.bit_sel = 3'h5;
    issue(bbx_pkg::OP_TFLAG_STORE_BIT);
    check("tstore", flags_o, f0 | 8'h40);
    rq.rd_val = 8'h81;
    rq.bit_sel = 3'h2;
    issue(bbx_pkg::OP_TFLAG_LOAD_BIT);
    check("tload", {res_o.reg_we, res_o.reg_data}, 16'h0185);
    check("tload_flags", flags_o, f0);
  endtask
  task automatic t_arith();
    set_flags(8'h01);
    for (int i = 0; i < 5; i++)
    begin
      rq.rd_val = 8'h81;
      issue(SHIFTS[i]);
      check("sh_res", {res_o.reg_we, res_o.reg_data}, {8'h01, SH_RES[i]});
      check("sh_flags", flags_o[3:0], {!SH_RES[i][7], SH_RES[i][7], 2'b01});
    end
    set_flags(8'h00);
    rq.rd_val = 8'h10;
    rq.rr_val = 8'h10;
    rq.imm = 8'h20;
    issue(bbx_pkg::OP_COMPARE);
    check("cp", {res_o.reg_we, flags_o & 8'h2f}, 16'h0002);
    issue(bbx_pkg::OP_COMPARE_IMM);
    check("cpi", {res_o.reg_we, flags_o & 8'h2f}, 16'h0005);
    rq.rr_val = 8'h0f;
    issue(bbx_pkg::OP_COMPARE_CARRY);
    check("cpc", {res_o.reg_we, flags_o & 8'h2f, cyc[1:0]}, 16'h0081);
  endtask

  // ==========================================================
  // clock, watchdog and main sequence
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial
  begin
    #2000000;
    failures++;
    stop_test();
  end
  initial
  begin
    failures = 0;
    tests_run = 0;
    resetn_i = 1'b0;
    req_valid_i = 1'b0;
    rq = '0;
    repeat (2) @(negedge clock_i);
    resetn_i = 1'b1;
    @(negedge clock_i);
    check("rst_state", {done_o, req_ready_o, flags_o}, {1'b0, 1'b1, bbx_pkg::FLAGS_RESET});
    check("rst_pc", pc_o, bbx_pkg::PC_RESET);
    t_branch();
    t_signed();
    t_calls();
    t_skip();
    t_bits();
    t_arith();
    stop_test();
  end
endmodule

bind bbx_exec bbx_exec_asserts bbx_exec_asserts_i (.clock_i(clock_i), .resetn_i(resetn_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
  .pc_o(pc_o), .flags_o(flags_o), .res_o(res_o));
